// [rtl/sfrb_pkg.sv]
// package: address map, field masks and reset values of the bank-1 registers
package sfrb_pkg;
  // ==================================================================
  // widths
  localparam int unsigned SFRB_DATA_W = 8;
  localparam int unsigned SFRB_ADDR_W = 8;
  localparam int unsigned SFRB_PC_W = 13;
  localparam int unsigned SFRB_MEM_ADDR_W = 9;

  // ==================================================================
  // register addresses (bank 1); mirrored ones also answer in bank 0
  localparam logic [7:0] SFRB_ADR_INDIRECT = 8'h80;
  localparam logic [7:0] SFRB_ADR_OPTION = 8'h81;
  localparam logic [7:0] SFRB_ADR_PCL = 8'h82;
  localparam logic [7:0] SFRB_ADR_STATUS = 8'h83;
  localparam logic [7:0] SFRB_ADR_POINTER = 8'h84;
  localparam logic [7:0] SFRB_ADR_DIR_A = 8'h85;
  localparam logic [7:0] SFRB_ADR_DIR_B = 8'h86;
  localparam logic [7:0] SFRB_ADR_DIR_C = 8'h87;
  localparam logic [7:0] SFRB_ADR_PC_LATCH = 8'h8A;
  localparam logic [7:0] SFRB_ADR_INT_CTRL = 8'h8B;
  localparam logic [7:0] SFRB_ADR_PIRQ_EN = 8'h8C;
  localparam logic [7:0] SFRB_ADR_PWR_FLAGS = 8'h8E;
  localparam logic [7:0] SFRB_ADR_T2_PERIOD = 8'h92;
  localparam logic [7:0] SFRB_ADR_SER_ADDR = 8'h93;
  localparam logic [7:0] SFRB_ADR_SER_STAT = 8'h94;

  // ==================================================================
  // implemented-bit masks, plus the status software-write and interrupt-control reset-keep masks
  localparam logic [7:0] SFRB_MASK_DIR_A = 8'h3F;
  localparam logic [7:0] SFRB_MASK_PC_LATCH = 8'h1F;
  localparam logic [7:0] SFRB_MASK_PIRQ_EN = 8'hCF;
  localparam logic [7:0] SFRB_MASK_PWR_FLAGS = 8'h03;
  localparam logic [7:0] SFRB_MASK_SER_STAT = 8'h3F;
  localparam logic [7:0] SFRB_MASK_STATUS_SW = 8'hE7;
  localparam logic [7:0] SFRB_MASK_INT_KEEP = 8'h01;

  // ==================================================================
  // status and power flag bit positions
  localparam int unsigned SFRB_STAT_IRP = 7;
  localparam int unsigned SFRB_STAT_TO = 4;
  localparam int unsigned SFRB_STAT_PD = 3;
  localparam int unsigned SFRB_PWR_POR = 1;
  localparam int unsigned SFRB_PWR_BOR = 0;

  // ==================================================================
  // reset values
  localparam logic [7:0] SFRB_RST_ZERO = 8'h00;
  localparam logic [7:0] SFRB_RST_ONES = 8'hFF;
  localparam logic [7:0] SFRB_RST_STATUS_POR = 8'h18;

  // reset cause applied in a cycle
  typedef enum logic [1:0] {
    SFRB_RK_NONE,
    SFRB_RK_BROWN,
    SFRB_RK_WDT,
    SFRB_RK_EXT
  } sfrb_rst_t;
endpackage

// [rtl/sfrb_bank1.sv]
// module: bank-1 special function register bank of the 8-bit core
`timescale 1ns/1ps
`default_nettype none
module sfrb_bank1
  import sfrb_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [sfrb_pkg::SFRB_ADDR_W-1:0] ADDR,
  input wire logic [sfrb_pkg::SFRB_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] RDATA,
  input wire logic BROWNOUT_EVT,
  input wire logic WDT_EVT,
  input wire logic EXT_RST_EVT,
  input wire logic ASLEEP,
  input wire logic CLRWDT_EVT,
  input wire logic SLEEP_EVT,
  input wire logic ALU_FLAG_WE,
  input wire logic [2:0] ALU_FLAGS,
  input wire logic PC_INC,
  input wire logic [sfrb_pkg::SFRB_DATA_W-1:0] SER_STAT_IN,
  output logic [sfrb_pkg::SFRB_PC_W-1:0] PC,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] OPTION_CFG,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] STATUS,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] DIR_A,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] DIR_B,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] DIR_C,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] INT_CTRL,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] PIRQ_EN,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] PWR_FLAGS,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] T2_PERIOD,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] SER_ADDR,
  output logic [sfrb_pkg::SFRB_MEM_ADDR_W-1:0] MEM_ADDR,
  output logic [sfrb_pkg::SFRB_DATA_W-1:0] MEM_WDATA,
  output logic MEM_WR,
  output logic MEM_RD,
  input wire logic [sfrb_pkg::SFRB_DATA_W-1:0] MEM_RDATA
);
  import sfrb_pkg::*;

  // ==================================================================
  // address decode

  // mirrored registers ignore the bank bit of the address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off,
                               input logic mir);
    hit = (a == off) || (mir && (a[6:0] == off[6:0]));
  endfunction

  logic h_ind, h_opt, h_pcl, h_stat, h_ptr, h_dira, h_dirb, h_dirc;
  logic h_pcl8, h_intc, h_pie, h_pwr, h_pr2, h_sadr, h_sst;
  logic ind_self;

  // mirrored set answers in both banks
  always_comb begin
    h_ind = hit(ADDR, SFRB_ADR_INDIRECT, 1'b1);
    h_pcl = hit(ADDR, SFRB_ADR_PCL, 1'b1);
    h_stat = hit(ADDR, SFRB_ADR_STATUS, 1'b1);
    h_ptr = hit(ADDR, SFRB_ADR_POINTER, 1'b1);
    h_pcl8 = hit(ADDR, SFRB_ADR_PC_LATCH, 1'b1);
    h_intc = hit(ADDR, SFRB_ADR_INT_CTRL, 1'b1);
    h_opt = hit(ADDR, SFRB_ADR_OPTION, 1'b0);
    h_dira = hit(ADDR, SFRB_ADR_DIR_A, 1'b0);
    h_dirb = hit(ADDR, SFRB_ADR_DIR_B, 1'b0);
    h_dirc = hit(ADDR, SFRB_ADR_DIR_C, 1'b0);
    h_pie = hit(ADDR, SFRB_ADR_PIRQ_EN, 1'b0);
    h_pwr = hit(ADDR, SFRB_ADR_PWR_FLAGS, 1'b0);
    h_pr2 = hit(ADDR, SFRB_ADR_T2_PERIOD, 1'b0);
    h_sadr = hit(ADDR, SFRB_ADR_SER_ADDR, 1'b0);
    h_sst = hit(ADDR, SFRB_ADR_SER_STAT, 1'b0);
  end

  // ==================================================================
  // registers
  logic [12:0] pc_q, pc_d;
  logic [7:0] opt_q, opt_d, stat_q, stat_d, ptr_q, ptr_d;
  logic [7:0] dira_q, dira_d, dirb_q, dirb_d, dirc_q, dirc_d;
  logic [7:0] pcl8_q, pcl8_d, intc_q, intc_d, pie_q, pie_d;
  logic [7:0] pwr_q, pwr_d, pr2_q, pr2_d, sadr_q, sadr_d, sst_q, sst_d;
  logic [7:0] rdata_q, rdata_d;
  sfrb_rst_t rk;

  // pointer aimed back at the indirect port itself: reads 0, writes drop
  assign ind_self = (ptr_q[6:0] == SFRB_ADR_INDIRECT[6:0]);

  // ==================================================================
  // indirect access port: a window, no storage of its own
  assign MEM_ADDR = {stat_q[SFRB_STAT_IRP], ptr_q};
  assign MEM_WDATA = WDATA;
  assign MEM_WR = WR && h_ind && !ind_self;
  assign MEM_RD = RD && h_ind && !ind_self;

  // reset cause; brown-out outranks the others when several coincide
  always_comb begin
    if (BROWNOUT_EVT) begin
      rk = SFRB_RK_BROWN;
    end else if (WDT_EVT) begin
      rk = SFRB_RK_WDT;
    end else if (EXT_RST_EVT) begin
      rk = SFRB_RK_EXT;
    end else begin
      rk = SFRB_RK_NONE;
    end
  end

  // ==================================================================
  // next-state for the whole bank
  always_comb begin
    pc_d = pc_q;
    opt_d = opt_q;
    stat_d = stat_q;
    ptr_d = ptr_q;
    dira_d = dira_q;
    dirb_d = dirb_q;
    dirc_d = dirc_q;
    pcl8_d = pcl8_q;
    intc_d = intc_q;
    pie_d = pie_q;
    pwr_d = pwr_q;
    pr2_d = pr2_q;
    sadr_d = sadr_q;
    sst_d = SER_STAT_IN & SFRB_MASK_SER_STAT;
    case (rk)
      SFRB_RK_BROWN: begin
        // power-up column, but the power-on flag survives a brown-out
        pc_d = '0;
        opt_d = SFRB_RST_ONES;
        stat_d = SFRB_RST_STATUS_POR;
        ptr_d = SFRB_RST_ZERO;
        dira_d = SFRB_RST_ONES & SFRB_MASK_DIR_A;
        dirb_d = SFRB_RST_ONES;
        dirc_d = SFRB_RST_ONES;
        pcl8_d = SFRB_RST_ZERO;
        intc_d = SFRB_RST_ZERO;
        pie_d = SFRB_RST_ZERO;
        pwr_d[SFRB_PWR_BOR] = 1'b0;
        pr2_d = SFRB_RST_ONES;
        sadr_d = SFRB_RST_ZERO;
        sst_d = SFRB_RST_ZERO;
      end
      SFRB_RK_WDT, SFRB_RK_EXT: begin
        // second column: pointer, low flags and power flags kept
        pc_d = '0;
        opt_d = SFRB_RST_ONES;
        stat_d = stat_q & ~SFRB_MASK_STATUS_SW;
        stat_d[2:0] = stat_q[2:0];
        if (rk == SFRB_RK_WDT) begin
          // timeout cause shows in the two conditional bits
          stat_d[SFRB_STAT_TO] = 1'b0;
          stat_d[SFRB_STAT_PD] = !ASLEEP;
        end
        dira_d = SFRB_RST_ONES & SFRB_MASK_DIR_A;
        dirb_d = SFRB_RST_ONES;
        dirc_d = SFRB_RST_ONES;
        pcl8_d = SFRB_RST_ZERO;
        intc_d = intc_q & SFRB_MASK_INT_KEEP;
        pie_d = SFRB_RST_ZERO;
        pr2_d = SFRB_RST_ONES;
        sadr_d = SFRB_RST_ZERO;
        sst_d = SFRB_RST_ZERO;
      end
      default: begin
        // program counter: a write of the low byte pulls in the latch
        if (WR && h_pcl) begin
          pc_d = {pcl8_q[4:0], WDATA};
        end else if (PC_INC) begin
          pc_d = pc_q + 13'h0001;
        end
        // core watchdog / sleep instructions drive the two time-out bits
        if (CLRWDT_EVT || SLEEP_EVT) begin
          stat_d[SFRB_STAT_TO] = 1'b1;
          stat_d[SFRB_STAT_PD] = !SLEEP_EVT;
        end
        if (WR && h_stat) begin
          // the two time-out bits are not writable by software
          stat_d = (WDATA & SFRB_MASK_STATUS_SW)
                 | (stat_d & ~SFRB_MASK_STATUS_SW);
        end
        // alu result flags win over a same-cycle software write
        if (ALU_FLAG_WE) begin
          stat_d[2:0] = ALU_FLAGS;
        end
        // unimplemented bits are masked on the way in
        if (WR && h_opt) opt_d = WDATA;
        if (WR && h_ptr) ptr_d = WDATA;
        if (WR && h_dira) dira_d = WDATA & SFRB_MASK_DIR_A;
        if (WR && h_dirb) dirb_d = WDATA;
        if (WR && h_dirc) dirc_d = WDATA;
        if (WR && h_pcl8) pcl8_d = WDATA & SFRB_MASK_PC_LATCH;
        if (WR && h_intc) intc_d = WDATA;
        if (WR && h_pie) pie_d = WDATA & SFRB_MASK_PIRQ_EN;
        if (WR && h_pwr) pwr_d = WDATA & SFRB_MASK_PWR_FLAGS;
        if (WR && h_pr2) pr2_d = WDATA;
        if (WR && h_sadr) sadr_d = WDATA;
      end
    endcase
  end

  // ==================================================================
  // read path: data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = SFRB_RST_ZERO;
    if (RD) begin
      if (h_ind) begin
        rdata_d = ind_self ? SFRB_RST_ZERO : MEM_RDATA;
      end else if (h_opt) begin
        rdata_d = opt_q;
      end else if (h_pcl) begin
        rdata_d = pc_q[7:0];
      end else if (h_stat) begin
        rdata_d = stat_q;
      end else if (h_ptr) begin
        rdata_d = ptr_q;
      end else if (h_dira) begin
        rdata_d = dira_q;
      end else if (h_dirb) begin
        rdata_d = dirb_q;
      end else if (h_dirc) begin
        rdata_d = dirc_q;
      end else if (h_pcl8) begin
        rdata_d = pcl8_q;
      end else if (h_intc) begin
        rdata_d = intc_q;
      end else if (h_pie) begin
        rdata_d = pie_q;
      end else if (h_pwr) begin
        rdata_d = pwr_q;
      end else if (h_pr2) begin
        rdata_d = pr2_q;
      end else if (h_sadr) begin
        rdata_d = sadr_q;
      end else if (h_sst) begin
        rdata_d = sst_q;
      end
    end
  end

  // ==================================================================
  // state registers; the async reset is the power-on reset
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pc_q <= '0;
      opt_q <= SFRB_RST_ONES;
      stat_q <= SFRB_RST_STATUS_POR;
      ptr_q <= SFRB_RST_ZERO;
      dira_q <= SFRB_RST_ONES & SFRB_MASK_DIR_A;
      dirb_q <= SFRB_RST_ONES;
      dirc_q <= SFRB_RST_ONES;
      pcl8_q <= SFRB_RST_ZERO;
      intc_q <= SFRB_RST_ZERO;
      pie_q <= SFRB_RST_ZERO;
      pwr_q <= SFRB_RST_ZERO;
      pr2_q <= SFRB_RST_ONES;
      sadr_q <= SFRB_RST_ZERO;
      sst_q <= SFRB_RST_ZERO;
      rdata_q <= SFRB_RST_ZERO;
    end else begin
      pc_q <= pc_d;
      opt_q <= opt_d;
      stat_q <= stat_d;
      ptr_q <= ptr_d;
      dira_q <= dira_d;
      dirb_q <= dirb_d;
      dirc_q <= dirc_d;
      pcl8_q <= pcl8_d;
      intc_q <= intc_d;
      pie_q <= pie_d;
      pwr_q <= pwr_d;
      pr2_q <= pr2_d;
      sadr_q <= sadr_d;
      sst_q <= sst_d;
      rdata_q <= rdata_d;
    end
  end

  // ==================================================================
  // outputs straight from the registers
  assign RDATA = rdata_q;
  assign PC = pc_q;
  assign OPTION_CFG = opt_q;
  assign STATUS = stat_q;
  assign DIR_A = dira_q;
  assign DIR_B = dirb_q;
  assign DIR_C = dirc_q;
  assign INT_CTRL = intc_q;
  assign PIRQ_EN = pie_q;
  assign PWR_FLAGS = pwr_q;
  assign T2_PERIOD = pr2_q;
  assign SER_ADDR = sadr_q;
endmodule
`default_nettype wire

// [bench/sfrb_bank1_properties.sv]
// checker: port-level properties of the bank-1 register block
`timescale 1ns/1ps
`default_nettype none
module sfrb_bank1_properties
  import sfrb_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic BROWNOUT_EVT,
  input wire logic WDT_EVT,
  input wire logic EXT_RST_EVT,
  input wire logic ASLEEP,
  input wire logic [12:0] PC,
  input wire logic [7:0] OPTION_CFG,
  input wire logic [7:0] STATUS,
  input wire logic [7:0] DIR_A,
  input wire logic [7:0] DIR_B,
  input wire logic [7:0] DIR_C,
  input wire logic [7:0] T2_PERIOD,
  input wire logic [8:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic [7:0] MEM_RDATA
);
  // ==================================================================
  // helpers
  logic any_evt;
  assign any_evt = BROWNOUT_EVT | WDT_EVT | EXT_RST_EVT;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // indirect read: request with a usable pointer, then memory answer
  sequence s_ind_req;
    RD && ADDR == 8'h80 && MEM_ADDR[6:0] != 7'h00;
  endsequence
  sequence s_ind_ans;
    MEM_RD ##1 RDATA == $past(MEM_RDATA);
  endsequence
  // ==================================================================
  // properties
  a_idle_rdata_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside answer");
  a_unmapped_read_zero: assert property (RD && ADDR inside {8'h88, 8'h89,
    8'h8D, 8'h8F, 8'h90, 8'h91, 8'h08} |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_dir_a_masked: assert property (DIR_A[7:6] == 2'b00)
    else $error("unimplemented direction bits set");
  a_pc_low_load: assert property (WR && ADDR[6:0] == 7'h02
    && !any_evt |=> PC[7:0] == $past(WDATA))
    else $error("pc low not loaded");
  a_ind_redirect: assert property (s_ind_req |-> s_ind_ans)
    else $error("indirect read not redirected");
  a_dir_evt_ones: assert property (any_evt |=> DIR_A == 8'h3F
    && DIR_B == 8'hFF && DIR_C == 8'hFF) else $error("direction not ones");
  a_opt_evt_ones: assert property (any_evt |=> OPTION_CFG == 8'hFF
    && T2_PERIOD == 8'hFF) else $error("option or period not ones");
  a_ptr_kept: assert property ((WDT_EVT || EXT_RST_EVT)
    && !BROWNOUT_EVT |=> $stable(MEM_ADDR[7:0]))
    else $error("pointer lost on reset");
  a_wdt_status: assert property (WDT_EVT && !BROWNOUT_EVT |=>
    STATUS[7:3] == {4'h0, !$past(ASLEEP)}) else $error("watchdog status");
  a_ext_status: assert property (EXT_RST_EVT && !WDT_EVT
    && !BROWNOUT_EVT |=> STATUS[4:3] == $past(STATUS[4:3]))
    else $error("pin reset status");
endmodule
`default_nettype wire

// [bench/sfrb_bank1_tb_top.sv]
// testbench: bank-1 register block against a behavioural register model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end
module sfrb_bank1_tb_top;
  import sfrb_pkg::*;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic WR = 1'b0, RD = 1'b0, PC_INC = 1'b0, ASLEEP = 1'b0;
  logic BROWNOUT_EVT = 1'b0, WDT_EVT = 1'b0, EXT_RST_EVT = 1'b0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00;
  logic [7:0] MEM_RDATA = 8'h00, SER_STAT_IN = 8'h00;
  logic [7:0] RDATA, OPTION_CFG, STATUS, DIR_A, DIR_B, DIR_C, INT_CTRL;
  logic [7:0] PIRQ_EN, PWR_FLAGS, T2_PERIOD, SER_ADDR, MEM_WDATA;
  logic [12:0] PC;
  logic [8:0] MEM_ADDR;
  logic MEM_WR, MEM_RD;
  logic [7:0] m [int];
  logic [31:0] seed = 32'd78;
  logic [31:0] r;
  logic [7:0] wd;
  int n_errors = 0;
  int comparisons = 0;
  // ==================================================================
  // clock and design
  always #2.5 MCLK = ~MCLK;
  sfrb_bank1 uut (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .BROWNOUT_EVT(BROWNOUT_EVT), .WDT_EVT(WDT_EVT),
    .EXT_RST_EVT(EXT_RST_EVT), .ASLEEP(ASLEEP), .CLRWDT_EVT(1'b0),
    .SLEEP_EVT(1'b0), .ALU_FLAG_WE(1'b0), .ALU_FLAGS(3'h0), .PC_INC(PC_INC),
    .SER_STAT_IN(SER_STAT_IN), .PC(PC), .OPTION_CFG(OPTION_CFG),
    .STATUS(STATUS), .DIR_A(DIR_A), .DIR_B(DIR_B), .DIR_C(DIR_C),
    .INT_CTRL(INT_CTRL), .PIRQ_EN(PIRQ_EN), .PWR_FLAGS(PWR_FLAGS),
    .T2_PERIOD(T2_PERIOD), .SER_ADDR(SER_ADDR), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
    .MEM_RDATA(MEM_RDATA));
  // ==================================================================
  // model: xorshift source, address folding, masks, reset columns
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // mirrored registers fold onto bank 1; other bank-0 places are not here
  function automatic int key(logic [7:0] a);
    // option at 0x81 is not mirrored, so 0x01 must not fold onto it
    if (a[6:0] inside {7'h00, [7'h02:7'h04], 7'h0A, 7'h0B}) begin
      return {1'b1, a[6:0]};
    end
    return a[7] ? int'(a) : -1;
  endfunction
  function automatic logic [7:0] mask(int k);
    case (k)
      8'h85: return 8'h3F;
      8'h8A: return 8'h1F;
      8'h8C: return 8'hCF;
      8'h8E: return 8'h03;
      8'h81, 8'h82, 8'h84, 8'h86, 8'h87, 8'h8B, 8'h92, 8'h93: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] mget(int k);
    if (k == 8'h80) return (m[8'h84][6:0] != 7'h00) ? MEM_RDATA : 8'h00;
    if (k == 8'h94) return SER_STAT_IN & 8'h3F;
    return m.exists(k) ? m[k] : 8'h00;
  endfunction
  // kind: 0 power-on, 1 watchdog, 2 pin, 3 brown-out
  task automatic mrst(int kind);
    logic [7:0] st;
    st = m.exists(8'h83) ? m[8'h83] : 8'h00;
    m[8'h81] = 8'hFF;
    m[8'h82] = 8'h00;
    m[8'h85] = 8'h3F;
    m[8'h86] = 8'hFF;
    m[8'h87] = 8'hFF;
    m[8'h8A] = 8'h00;
    m[8'h8C] = 8'h00;
    m[8'h92] = 8'hFF;
    m[8'h93] = 8'h00;
    if (kind == 0 || kind == 3) begin
      m[8'h8E] = (kind == 0) ? 8'h00 : {6'h00, m[8'h8E][1], 1'b0};
      m[8'h83] = 8'h18;
      m[8'h84] = 8'h00;
      m[8'h8B] = 8'h00;
    end else begin
      m[8'h8B] = m[8'h8B] & 8'h01;
      m[8'h83] = {3'b000, (kind == 1) ? {1'b0, !ASLEEP} : st[4:3], st[2:0]};
    end
  endtask
  // ==================================================================
  // bus tasks
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic iw;
    iw = (key(a) == 8'h80) && (m[8'h84][6:0] != 7'h00);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    #1;
    `CHK({MEM_WR, MEM_WDATA, MEM_ADDR}, {iw, d, m[8'h83][7], m[8'h84]})
    @(posedge MCLK);
    WR <= 1'b0;
    if (mask(key(a)) != 8'h00) m[key(a)] = d & mask(key(a));
    @(posedge MCLK);
  endtask
  task automatic rd(logic [7:0] a);
    logic [7:0] e;
    e = mget(key(a));
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    `CHK(RDATA, e)
    @(posedge MCLK);
  endtask
  // both banks, every place from 0x00 to 0x1F
  task automatic sweep(string name);
    for (int a = 0; a < 32; a++) begin
      rd(8'h80 | a[7:0]);
      rd(a[7:0]);
    end
    // register outputs must agree with what the reads returned
    #1;
    `CHK({STATUS, INT_CTRL, PIRQ_EN}, {m[8'h83], m[8'h8B], m[8'h8C]})
    `CHK({PWR_FLAGS, SER_ADDR}, {m[8'h8E], m[8'h93]})
    `CHK({OPTION_CFG, T2_PERIOD}, {m[8'h81], m[8'h92]})
    @(posedge MCLK);
    $display("test %s done", name);
  endtask
  task automatic evt(int kind);
    // random sleep state; the single watchdog event exercises only one of the two status outcomes
    r = rnd();
    ASLEEP <= r[0];
    BROWNOUT_EVT <= (kind == 3);
    WDT_EVT <= (kind == 1);
    EXT_RST_EVT <= (kind == 2);
    @(posedge MCLK);
    {BROWNOUT_EVT, WDT_EVT, EXT_RST_EVT} <= 3'b000;
    mrst(kind);
    #1;
    `CHK(PC, 13'h0000)
    `CHK({DIR_A, DIR_B, DIR_C}, 24'h3FFFFF)
    @(posedge MCLK);
    sweep("event_reset");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge MCLK);
    SYS_RST <= 1'b0;
    mrst(0);
    @(posedge MCLK);
    sweep("reset_values");
    // random traffic on both banks; status is left to the flag logic
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      MEM_RDATA <= r[23:16];
      SER_STAT_IN <= r[31:24];
      wd = r[15:8];
      if (r[4:0] == 5'h0E) wd[0] = 1'b1;
      if (r[4:0] == 5'h0C) wd[7:6] = 2'b00;
      // status is never written, so its reserved bank bits stay zero
      if (r[4:0] != 5'h03) begin
        wr({r[5], 2'b00, r[4:0]}, wd);
      end else begin
        @(posedge MCLK);
      end
    end
    sweep("random_writes");
    wr(8'h0A, 8'h15);
    wr(8'h82, 8'h34);
    #1;
    `CHK(PC, 13'h1534)
    @(posedge MCLK);
    PC_INC <= 1'b1;
    @(posedge MCLK);
    PC_INC <= 1'b0;
    m[8'h82] = 8'h35;
    #1;
    `CHK(PC, 13'h1535)
    @(posedge MCLK);
    $display("test pc_latch done");
    evt(1);
    evt(2);
    evt(3);
    end_of_test();
  end
  // hang guard, far beyond the roughly 760 cycles the tests need
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
endmodule
bind sfrb_bank1 sfrb_bank1_properties u_props (.MCLK(MCLK),
  .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .BROWNOUT_EVT(BROWNOUT_EVT), .WDT_EVT(WDT_EVT),
  .EXT_RST_EVT(EXT_RST_EVT), .ASLEEP(ASLEEP), .PC(PC),
  .OPTION_CFG(OPTION_CFG), .STATUS(STATUS), .DIR_A(DIR_A), .DIR_B(DIR_B),
  .DIR_C(DIR_C), .T2_PERIOD(T2_PERIOD), .MEM_ADDR(MEM_ADDR),
  .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA));
`default_nettype wire
